/* File: logic/ctmw_pkg.sv */
// Package of constants and types for the CAN transceiver mode and wake block.
//==============================================================================
// Contract
// - After power-up the transceiver starts off, neither driving nor receiving.
// - In off mode bus wake events are ignored and raise no indication.
// - Off mode can be selected in every host chip operating mode.
// - Normal mode comes only from the mode bits, in host normal or stop.
// - Normal mode biases the bus to half the transceiver supply.
// - A low held across the delay end is not sent; next one is.
// - In normal mode the driver follows the transmit input.
// - Normal and receive-only modes present the received bus level.
// - Bit rates up to 2 Mbaud are supported.
// - Receive-only disables the driver while reception keeps working.
// - Receive-only is reachable only in host normal or stop mode.
// - Wake-capable is selectable in stop, sleep, restart and normal.
// - Entering host fail-safe forces the wake-capable mode.
// - A detected wake drives receive low until another mode is chosen or the wake rearms.
// - After a wake, software may switch to normal mode; it is accepted in host normal or stop.
// - Wake pattern needs two dominant phases between both wake time limits.
// - The dominant phases are split by a recessive phase within both limits.
// - The mode is chosen from dedicated software-written mode bits.
// - After a wake the mode still reads wake-capable and receive stays low.
// - Wake rearms on a mode toggle or entry to stop, sleep or fail-safe.
//==============================================================================
package ctmw_pkg;

	// Transceiver mode encodings as written by software.
	typedef enum logic [1:0] {
		CTMW_MODE_OFF   = 2'b00,
		CTMW_MODE_WAKE  = 2'b01,
		CTMW_MODE_NORM  = 2'b10,
		CTMW_MODE_RXO   = 2'b11
	} ctmw_mode_t;

	// Host chip operating modes.
	typedef enum logic [2:0] {
		CTMW_HOST_NORMAL   = 3'b000,
		CTMW_HOST_STOP     = 3'b001,
		CTMW_HOST_SLEEP    = 3'b010,
		CTMW_HOST_RESTART  = 3'b011,
		CTMW_HOST_FAILSAFE = 3'b100
	} ctmw_host_t;

	// Wake detector phases.
	typedef enum logic [2:0] {
		CTMW_WK_IDLE = 3'b000,
		CTMW_WK_DOM1 = 3'b001,
		CTMW_WK_REC  = 3'b010,
		CTMW_WK_DOM2 = 3'b011,
		CTMW_WK_DONE = 3'b100
	} ctmw_wk_t;

	// Default timings in oscillator cycles at 50 MHz (20 ns per cycle).
	localparam int CTMW_CLK_NS       = 20;
	localparam int CTMW_EN_DELAY_NS  = 20000;
	localparam int CTMW_WAKE1_NS     = 1000;
	localparam int CTMW_WAKE2_NS     = 1800000;
	localparam int CTMW_EN_DELAY_CYC =
		(CTMW_EN_DELAY_NS + CTMW_CLK_NS - 1) / CTMW_CLK_NS;
	localparam int CTMW_WAKE1_CYC    =
		(CTMW_WAKE1_NS + CTMW_CLK_NS - 1) / CTMW_CLK_NS;
	localparam int CTMW_WAKE2_CYC    = CTMW_WAKE2_NS / CTMW_CLK_NS;
	localparam int CTMW_MAX_BAUD     = 2000000;
	localparam int CTMW_CNT_W        = 24;

	localparam logic CTMW_RECESSIVE = 1'b1;
	localparam logic CTMW_DOMINANT  = 1'b0;

	// Outputs presented to the pins and to software.
	typedef struct packed {
		logic       bus_drive_dom;
		logic       bus_bias_half;
		logic       rx_out;
		logic       wake_flag;
		logic       tx_enabled;
		ctmw_mode_t mode_active;
	} ctmw_out_t;

endpackage

/* File: logic/ctmw_wake_det.sv */
// Wake pattern detector: dominant, recessive, dominant phases in a window.
`timescale 1ns/1ps
module ctmw_wake_det
	import ctmw_pkg::*;
#(
	parameter int MIN_CYC = CTMW_WAKE1_CYC,
	parameter int MAX_CYC = CTMW_WAKE2_CYC
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic arm,
	input  wire logic bus_level,
	output logic      detect
);

	//==========================================================================
	// State
	typedef struct packed {
		ctmw_wk_t              ph;
		logic [CTMW_CNT_W-1:0] cnt;
		logic                  det;
	} ctmw_wd_t;

	ctmw_wd_t st_r;
	ctmw_wd_t st_nxt;

	localparam logic [CTMW_CNT_W-1:0] MIN_C = CTMW_CNT_W'(MIN_CYC);
	localparam logic [CTMW_CNT_W-1:0] MAX_C = CTMW_CNT_W'(MAX_CYC);

	// A phase counts only if it is longer than the filter and shorter than
	// the window; the counter saturates so an endless phase cannot wrap.
	function automatic logic phase_ok(input logic [CTMW_CNT_W-1:0] c);
		phase_ok = (c > MIN_C) && (c < MAX_C);
	endfunction

	//==========================================================================
	// Phase tracking.
	always_comb begin
		st_nxt = st_r;
		if (st_r.cnt != {CTMW_CNT_W{1'b1}}) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
		if (!arm) begin
			st_nxt = '0;
			st_nxt.ph = CTMW_WK_IDLE;
		end else begin
			case (st_r.ph)
				CTMW_WK_IDLE: begin
					st_nxt.cnt = '0;
					if (bus_level == CTMW_DOMINANT) begin
						st_nxt.ph = CTMW_WK_DOM1;
					end
				end
				CTMW_WK_DOM1: begin
					if (bus_level == CTMW_RECESSIVE) begin
						st_nxt.cnt = '0;
						st_nxt.ph = phase_ok(st_r.cnt) ? CTMW_WK_REC
							: CTMW_WK_IDLE;
					end else if (st_r.cnt >= MAX_C) begin
						st_nxt.ph = CTMW_WK_IDLE;
					end
				end
				CTMW_WK_REC: begin
					if (bus_level == CTMW_DOMINANT) begin
						st_nxt.cnt = '0;
						st_nxt.ph = phase_ok(st_r.cnt) ? CTMW_WK_DOM2
							: CTMW_WK_DOM1;
					end else if (st_r.cnt >= MAX_C) begin
						st_nxt.ph = CTMW_WK_IDLE;
					end
				end
				CTMW_WK_DOM2: begin
					// The second phase completes when the bus returns recessive within both limits.
					if (st_r.cnt >= MAX_C) begin
						st_nxt.ph = CTMW_WK_IDLE;
					end else if (bus_level == CTMW_RECESSIVE) begin
						st_nxt.cnt = '0;
						if (phase_ok(st_r.cnt)) begin
							st_nxt.ph  = CTMW_WK_DONE;
							st_nxt.det = 1'b1;
						end else begin
							st_nxt.ph = CTMW_WK_IDLE;
						end
					end
				end
				CTMW_WK_DONE: begin
					st_nxt.det = 1'b1; // Held until disarmed.
				end
				default: begin
					st_nxt.ph = CTMW_WK_IDLE;
				end
			endcase
		end
	end

	//==========================================================================
	// Registers.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign detect = st_r.det;

endmodule

/* File: logic/ctmw_top.sv */
// Transceiver mode control, enabling delay, transmit gating and wake signal.
`timescale 1ns/1ps
module ctmw_top
	import ctmw_pkg::*;
#(
	parameter int EN_DELAY_CYC = CTMW_EN_DELAY_CYC,
	parameter int WAKE1_CYC    = CTMW_WAKE1_CYC,
	parameter int WAKE2_CYC    = CTMW_WAKE2_CYC
) (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [1:0] mode_req,
	input  wire logic       mode_wr,
	input  wire logic [2:0] host_mode,
	input  wire logic       bus_transmit_input,
	input  wire logic       bus_rx_level,
	output logic            bus_drive_dom,
	output logic            bus_bias_half,
	output logic            rx_out,
	output logic            wake_flag,
	output logic            tx_enabled,
	output logic [1:0]      mode_active
);

	//==========================================================================
	// State of the block in one struct.
	typedef struct packed {
		ctmw_mode_t            mode;
		ctmw_host_t            host;
		logic [CTMW_CNT_W-1:0] en_cnt;
		logic                  en_done;
		logic                  tx_armed;
		logic                  rearm;
		ctmw_out_t             o;
	} ctmw_st_t;

	ctmw_st_t st_r;
	ctmw_st_t st_nxt;

	localparam logic [CTMW_CNT_W-1:0] EN_C = CTMW_CNT_W'(EN_DELAY_CYC);

	logic       wake_det;
	logic       det_arm;
	ctmw_host_t host_in;

	assign host_in = ctmw_host_t'(host_mode);

	// Whether software may pick a given mode in a given host mode.
	function automatic logic mode_allowed(input ctmw_mode_t m,
		input ctmw_host_t h);
		case (m)
			CTMW_MODE_OFF:  mode_allowed = 1'b1;
			CTMW_MODE_NORM, CTMW_MODE_RXO:
				mode_allowed = (h == CTMW_HOST_NORMAL)
					|| (h == CTMW_HOST_STOP);
			CTMW_MODE_WAKE:
				mode_allowed = (h != CTMW_HOST_FAILSAFE)
					|| 1'b1;
			default:        mode_allowed = 1'b0;
		endcase
	endfunction

	// Host modes whose entry rearms the wake detector.
	function automatic logic host_rearms(input ctmw_host_t h);
		host_rearms = (h == CTMW_HOST_STOP) || (h == CTMW_HOST_SLEEP)
			|| (h == CTMW_HOST_FAILSAFE);
	endfunction

	//==========================================================================
	// The detector runs only in wake-capable mode; dropping arm for one
	// cycle clears its phase tracking and any latched wake.
	assign det_arm = (st_r.mode == CTMW_MODE_WAKE) && !st_r.rearm;

	ctmw_wake_det #(
		.MIN_CYC (WAKE1_CYC),
		.MAX_CYC (WAKE2_CYC)
	) u_wake (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.arm       (det_arm),
		.bus_level (bus_rx_level),
		.detect    (wake_det)
	);

	//==========================================================================
	// Next state.
	always_comb begin
		st_nxt       = st_r;
		st_nxt.host  = host_in;
		st_nxt.rearm = 1'b0;

		// Mode selection from the mode bits, refused when not available.
		if (mode_wr && mode_allowed(ctmw_mode_t'(mode_req), host_in)) begin
			st_nxt.mode = ctmw_mode_t'(mode_req);
		end
		// Fail-safe entry forces wake-capable mode.
		if (host_in == CTMW_HOST_FAILSAFE && st_r.host != CTMW_HOST_FAILSAFE)
		begin
			st_nxt.mode = CTMW_MODE_WAKE;
		end
		// Leaving host normal or stop drops modes that are not allowed there.
		if ((st_nxt.mode == CTMW_MODE_NORM || st_nxt.mode == CTMW_MODE_RXO)
			&& !mode_allowed(st_nxt.mode, host_in)) begin
			st_nxt.mode = CTMW_MODE_WAKE;
		end
		// Rearm on entry into stop, sleep or fail-safe.
		if (host_rearms(host_in) && host_in != st_r.host) begin
			st_nxt.rearm = 1'b1;
		end

		// Enabling delay restarts whenever normal mode is entered.
		if (st_nxt.mode != CTMW_MODE_NORM || st_r.mode != CTMW_MODE_NORM) begin
			st_nxt.en_cnt   = '0;
			st_nxt.en_done  = 1'b0;
			st_nxt.tx_armed = 1'b0;
		end else if (!st_r.en_done) begin
			if (st_r.en_cnt >= EN_C - 1'b1) begin
				st_nxt.en_done = 1'b1;
			end else begin
				st_nxt.en_cnt = st_r.en_cnt + 1'b1;
			end
		end else if (bus_transmit_input == CTMW_RECESSIVE) begin
			// A low held across the delay end waits for a recessive bit.
			st_nxt.tx_armed = 1'b1;
		end

		// Outputs.
		st_nxt.o.mode_active   = st_nxt.mode;
		st_nxt.o.tx_enabled    = st_nxt.tx_armed;
		st_nxt.o.bus_bias_half = (st_nxt.mode == CTMW_MODE_NORM)
			|| (st_nxt.mode == CTMW_MODE_RXO);
		st_nxt.o.bus_drive_dom = (st_nxt.mode == CTMW_MODE_NORM)
			&& st_nxt.tx_armed
			&& (bus_transmit_input == CTMW_DOMINANT);
		st_nxt.o.wake_flag     = (st_nxt.mode == CTMW_MODE_WAKE)
			&& wake_det && (st_nxt.mode == st_r.mode);
		case (st_nxt.mode)
			CTMW_MODE_NORM, CTMW_MODE_RXO:
				st_nxt.o.rx_out = bus_rx_level;
			CTMW_MODE_WAKE:
				st_nxt.o.rx_out = st_nxt.o.wake_flag ? CTMW_DOMINANT
					: CTMW_RECESSIVE;
			default:
				st_nxt.o.rx_out = CTMW_RECESSIVE;
		endcase
	end

	//==========================================================================
	// Registers; reset lands in off mode with the bus released.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_r          <= '0;
			st_r.mode     <= CTMW_MODE_OFF;
			st_r.host     <= CTMW_HOST_NORMAL;
			st_r.o.rx_out <= CTMW_RECESSIVE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus_drive_dom = st_r.o.bus_drive_dom;
	assign bus_bias_half = st_r.o.bus_bias_half;
	assign rx_out        = st_r.o.rx_out;
	assign wake_flag     = st_r.o.wake_flag;
	assign tx_enabled    = st_r.o.tx_enabled;
	assign mode_active   = st_r.o.mode_active;

endmodule

/* File: tb/ctmw_monitor.sv */
// Port checks for the CAN transceiver mode and wake block.
`timescale 1ns/1ps
module ctmw_monitor
	import ctmw_pkg::*;
#(
	parameter int EN_DELAY_CYC = CTMW_EN_DELAY_CYC,
	parameter int WAKE1_CYC    = CTMW_WAKE1_CYC,
	parameter int WAKE2_CYC    = CTMW_WAKE2_CYC
) (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       mode_wr,
	input wire logic [2:0] host_mode,
	input wire logic       bus_transmit_input,
	input wire logic       bus_drive_dom,
	input wire logic       bus_bias_half,
	input wire logic       rx_out,
	input wire logic       wake_flag,
	input wire logic       tx_enabled,
	input wire logic [1:0] mode_active
);
	// ==========
	// Checks
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Two cycles in a mode so registered outputs have caught up.
	AST_OFF_QUIET: assert property (
		$past(mode_active) == CTMW_MODE_OFF && mode_active == CTMW_MODE_OFF
		|-> !bus_drive_dom && !wake_flag) else $error("off mode active");
	AST_RXO_NO_DRIVE: assert property (
		$past(mode_active) == CTMW_MODE_RXO && mode_active == CTMW_MODE_RXO
		|-> !bus_drive_dom) else $error("driver on in rx-only");
	AST_BIAS: assert property (
		$stable(mode_active) |-> bus_bias_half == mode_active[1])
		else $error("bias wrong for mode");
	AST_NORM_HOST: assert property (
		mode_active == CTMW_MODE_NORM && $past(mode_active) != CTMW_MODE_NORM
		|-> $past(host_mode) inside {CTMW_HOST_NORMAL, CTMW_HOST_STOP})
		else $error("normal entered in wrong host mode");
	AST_FAILSAFE: assert property (
		host_mode == CTMW_HOST_FAILSAFE && !mode_wr
		&& $past(host_mode) != CTMW_HOST_FAILSAFE
		|=> mode_active == CTMW_MODE_WAKE) else $error("no forced wake");
	AST_WAKE_RX: assert property (
		wake_flag && $past(wake_flag) |-> !rx_out) else $error("rx not low");
	AST_WAKE_MODE: assert property (
		wake_flag && $stable(mode_active) |-> mode_active == CTMW_MODE_WAKE)
		else $error("wake flag outside wake mode");
	AST_EN_DELAY: assert property (
		$rose(mode_active == CTMW_MODE_NORM) |-> !tx_enabled [*8])
		else $error("transmit enabled too early");
	AST_TX_GATE: assert property (
		!tx_enabled && !$past(tx_enabled) |-> !bus_drive_dom)
		else $error("drive before enable");
	AST_FOLLOW: assert property (
		tx_enabled && $past(tx_enabled) && mode_active == CTMW_MODE_NORM
		&& $past(mode_active) == CTMW_MODE_NORM
		|-> bus_drive_dom == !$past(bus_transmit_input))
		else $error("driver does not follow transmit");
endmodule

/* File: tb/ctmw_can_ctrl.sv */
// Behavioural CAN protocol controller driving the transmit input.
`timescale 1ns/1ps
module ctmw_can_ctrl (
	input  wire logic tx_enabled,
	input  wire logic bit_val,
	input  wire logic early_low,
	output logic      tx
);
	// ==========
	// Transmit drive
	// Recessive until enabled; early_low models a controller jumping in.
	always_comb begin
		if (early_low) begin
			tx = 1'b0;
		end else if (tx_enabled) begin
			tx = bit_val;
		end else begin
			tx = 1'b1;
		end
	end
endmodule

/* File: tb/can_transceiver_mode_wake_bench.sv */
// Self-checking bench for the CAN transceiver mode and wake block.
`timescale 1ns/1ps
module can_transceiver_mode_wake_bench;
	import ctmw_pkg::*;
	logic       clock = 1'b0;
	logic       sys_rst = 1'b1;
	logic [1:0] mode_req = 2'h0;
	logic       mode_wr = 1'b0;
	logic [2:0] host_mode = 3'h0;
	logic       bus_rx_level = 1'b1;
	logic       bit_val = 1'b1;
	logic       early_low = 1'b0;
	logic       tx, drv, bias, rxo, wk, txen;
	logic [1:0] mact;
	logic [5:0] pat = 6'h13;
	int         err_total = 0;
	int         checks = 0;
	// ==========
	// Clock, design and controller
	always #10 clock = ~clock;
	ctmw_top #(.EN_DELAY_CYC(8), .WAKE1_CYC(4), .WAKE2_CYC(40))
	ctmw_top_inst (.clock, .sys_rst, .mode_req, .mode_wr, .host_mode,
		.bus_transmit_input(tx), .bus_rx_level, .bus_drive_dom(drv),
		.bus_bias_half(bias), .rx_out(rxo), .wake_flag(wk),
		.tx_enabled(txen), .mode_active(mact));
	ctmw_can_ctrl ctmw_can_ctrl_inst (.tx_enabled(txen), .bit_val,
		.early_low, .tx);
	// ==========
	// Tasks
	// Every input changes at the falling edge, clear of sampling.
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input string s, input logic [1:0] e,
		input logic [1:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] m);
		mode_req = m;
		mode_wr = 1'b1;
		cyc(1);
		mode_wr = 1'b0;
		cyc(2);
	endtask
	task automatic host(input logic [2:0] h);
		host_mode = h;
		cyc(2);
	endtask
	task automatic ph(input logic l, input int n);
		bus_rx_level = l;
		cyc(n);
	endtask
	// Dominant, recessive, dominant of d cycles, then a settling gap.
	task automatic wake_pattern(input int d);
		ph(1'b0, d);
		ph(1'b1, d);
		ph(1'b0, d);
		ph(1'b1, 6);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========
	// Tests
	initial begin
		cyc(4);
		sys_rst = 1'b0;
		chk("mode", CTMW_MODE_OFF, mact);
		chk("rx", 1'b1, rxo);
		wake_pattern(8);
		chk("wake", 1'b0, wk);
		$display("test reset and off done");
		for (int h = 0; h < 5; h++) begin
			host(h[2:0]);
			wr(CTMW_MODE_NORM);
			chk("norm", h < 2, mact == CTMW_MODE_NORM);
			wr(CTMW_MODE_RXO);
			chk("rxo", h < 2, mact == CTMW_MODE_RXO);
			wr(CTMW_MODE_WAKE);
			chk("wkm", CTMW_MODE_WAKE, mact);
			wr(CTMW_MODE_OFF);
			chk("off", CTMW_MODE_OFF, mact);
		end
		$display("test mode table done");
		host(3'h0);
		early_low = 1'b1;
		wr(CTMW_MODE_NORM);
		cyc(12);
		chk("txen", 1'b0, txen);
		chk("drv", 1'b0, drv);
		chk("bias", 1'b1, bias);
		early_low = 1'b0;
		cyc(3);
		chk("txen", 1'b1, txen);
		for (int i = 0; i < 6; i++) begin
			bit_val = pat[i];
			bus_rx_level = pat[i];
			cyc(1);
			chk("drv", !pat[i], drv);
			chk("rx", pat[i], rxo);
		end
		bit_val = 1'b1;
		wr(CTMW_MODE_RXO);
		early_low = 1'b1;
		for (int i = 0; i < 6; i++) begin
			ph(pat[i], 1);
			chk("drv", 1'b0, drv);
			chk("rx", pat[i], rxo);
		end
		early_low = 1'b0;
		$display("test transmit done");
		host(3'h1);
		wr(CTMW_MODE_WAKE);
		wake_pattern(2);
		chk("wake", 1'b0, wk);
		wake_pattern(50);
		chk("wake", 1'b0, wk);
		wake_pattern(10);
		chk("wake", 1'b1, wk);
		ph(1'b1, 20);
		chk("rx", 1'b0, rxo);
		chk("mode", CTMW_MODE_WAKE, mact);
		wr(CTMW_MODE_NORM);
		chk("mode", CTMW_MODE_NORM, mact);
		chk("rx", 1'b1, rxo);
		wr(CTMW_MODE_WAKE);
		wake_pattern(10);
		chk("wake", 1'b1, wk);
		host(3'h2);
		// The rearm pulse clears the detector one edge after host entry,
		// and the latched flag follows one edge later still.
		cyc(1);
		chk("wake", 1'b0, wk);
		wake_pattern(10);
		chk("wake", 1'b1, wk);
		$display("test wake done");
		host(3'h0);
		wr(CTMW_MODE_NORM);
		host(3'h4);
		chk("mode", CTMW_MODE_WAKE, mact);
		$display("test fail-safe done");
		final_report;
	end
	// Cut a hang short well beyond the roughly 460 cycles needed.
	initial begin
		#200000;
		err_total++;
		final_report;
	end
endmodule
bind ctmw_top ctmw_monitor #(.EN_DELAY_CYC(EN_DELAY_CYC),
	.WAKE1_CYC(WAKE1_CYC), .WAKE2_CYC(WAKE2_CYC)) ctmw_monitor_inst (
	.clock, .sys_rst, .mode_wr, .host_mode, .bus_transmit_input,
	.bus_drive_dom, .bus_bias_half, .rx_out, .wake_flag, .tx_enabled,
	.mode_active);
